// [rtl/fault_power_cycle_sequencer.sv]
// fault power-cycle sequencer with axi4-lite registers
//
// Added by the designer: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module fault_power_cycle_sequencer #(
   parameter int MS_CYC = pcyc_pkg::MS_CYC
) (
   input  wire logic                   mclk,
   input  wire logic                   rst,
   input  wire pcyc_pkg::axi_req_t     axi_req,
   output pcyc_pkg::axi_rsp_t          axi_rsp,
   input  wire logic [pcyc_pkg::NR-1:0] rail_fault,
   input  wire logic [pcyc_pkg::NR-1:0] rail_pgood,
   input  wire logic [pcyc_pkg::NR-1:0] rail_low,
   input  wire logic [pcyc_pkg::NG-1:0] gpi,
   output logic      [pcyc_pkg::NR-1:0] rail_en,
   output logic                        irq
);
   localparam int NR = pcyc_pkg::NR;

   pcyc_pkg::st_t s_r, s_nxt;
   logic [NR-1:0] good, hit, newf;
   logic [10:0]   dly_ms;
   logic [2:0]    att_lim;
   logic [3:0]    rty_lim;
   logic          ms_p;

   // lowest set bit as a one-hot vector
   function automatic logic [NR-1:0] lo1(input logic [NR-1:0] v);
      lo1 = v & (~v + NR'(1));
   endfunction

   // highest set bit as a one-hot vector
   function automatic logic [NR-1:0] hi1(input logic [NR-1:0] v);
      hi1 = '0;
      for (int i = 0; i < NR; i++)
      begin
         if (v[i])
            hi1 = NR'(1) << i;
      end
   endfunction

   // union of the follower sets of every rail in v
   function automatic logic [NR-1:0] folof(input logic [NR-1:0] v,
                                           input logic [NR-1:0][NR-1:0] f);
      folof = '0;
      for (int i = 0; i < NR; i++)
      begin
         if (v[i])
            folof = folof | f[i];
      end
   endfunction

   // follower table decode, shared by reads and writes
   function automatic logic fol_hit(input logic [7:0] a);
      fol_hit = (a[7:6] == pcyc_pkg::A_FOLHI) && (a[5:2] < 4'(NR));
   endfunction

   // byte-lane merge of a write
   function automatic logic [31:0] wmerge(input logic [31:0] o,
                                          input logic [31:0] d,
                                          input logic [3:0]  st);
      for (int b = 0; b < 4; b++)
         o[b*8 +: 8] = st[b] ? d[b*8 +: 8] : o[b*8 +: 8];
      wmerge = o;
   endfunction

   // a rail without monitor counts as good once enabled
   assign good    = s_r.pg2 | (s_r.nomon & s_r.en);
   assign hit     = rail_fault & s_r.rsq & ~s_r.dead;
   assign newf    = hit & ~s_r.grp; // group faults drop out
   assign dly_ms  = 11'(s_r.dly) * pcyc_pkg::STEP_MS;
   assign att_lim = 3'(s_r.ctrl[pcyc_pkg::CT_ATT +: 2]) + 3'h1;
   assign rty_lim = (s_r.ctrl[pcyc_pkg::CT_RTY +: 4] > pcyc_pkg::RTY_MAX) ?
                    pcyc_pkg::RTY_MAX : s_r.ctrl[pcyc_pkg::CT_RTY +: 4];
   assign ms_p    = (s_r.tick == 14'(MS_CYC - 1));

   // whole next state
   always_comb
   begin
      logic [31:0]   rd;
      logic [31:0]   wv;
      logic [3:0]    ev;
      logic [3:0]    clr;
      logic [NR-1:0] c;
      logic          fail;
      rd   = '0;
      wv   = '0;
      ev   = '0;
      clr  = '0;
      c    = '0;
      fail = 1'b0;
      s_nxt = s_r;
      // two-stage synchronisers for the pgood, low and gpi pins
      s_nxt.pg1 = rail_pgood;
      s_nxt.pg2 = s_r.pg1;
      s_nxt.of1 = rail_low;
      s_nxt.of2 = s_r.of1;
      s_nxt.gp1 = gpi;
      s_nxt.gp2 = s_r.gp1;
      s_nxt.tick = ms_p ? '0 : s_r.tick + 14'h1;
      s_nxt.ms = ms_p ? s_r.ms + 11'h1 : s_r.ms;
      s_nxt.ctrl[pcyc_pkg::CT_GO] = 1'b0;

      // write side: address and data taken in either order
      if (axi_req.awvalid && s_r.bus.awready)
      begin
         s_nxt.awok = 1'b1;
         s_nxt.awa = axi_req.awaddr;
      end
      if (axi_req.wvalid && s_r.bus.wready)
      begin
         s_nxt.wok = 1'b1;
         s_nxt.wd = axi_req.wdata;
         s_nxt.ws = axi_req.wstrb;
      end
      if (s_r.bus.bvalid && axi_req.bready)
         s_nxt.bus.bvalid = 1'b0;
      if (s_r.awok && s_r.wok && !s_r.bus.bvalid)
      begin
         s_nxt.awok = 1'b0;
         s_nxt.wok = 1'b0;
         s_nxt.bus.bvalid = 1'b1;
         s_nxt.bus.bresp = pcyc_pkg::R_OKAY;
         case (s_r.awa)
            pcyc_pkg::A_CTRL:
            begin
               wv = wmerge({20'h0, s_r.ctrl}, s_r.wd, s_r.ws);
               s_nxt.ctrl = wv[11:0];
            end
            pcyc_pkg::A_DLY:   s_nxt.dly = s_r.ws[0] ? s_r.wd[7:0] : s_r.dly;
            pcyc_pkg::A_TOFF:  s_nxt.toff = s_r.ws[0] ? s_r.wd[7:0] : s_r.toff;
            pcyc_pkg::A_TON:   s_nxt.ton = s_r.ws[0] ? s_r.wd[7:0] : s_r.ton;
            pcyc_pkg::A_CONT:  s_nxt.cont = s_r.ws[0] ? s_r.wd[7:0] : s_r.cont;
            pcyc_pkg::A_RSQ:
            begin
               wv = wmerge({20'h0, s_r.rsq}, s_r.wd, s_r.ws);
               s_nxt.rsq = wv[11:0];
            end
            pcyc_pkg::A_IMM:
            begin
               wv = wmerge({20'h0, s_r.imm}, s_r.wd, s_r.ws);
               s_nxt.imm = wv[11:0];
            end
            pcyc_pkg::A_NOMON:
            begin
               wv = wmerge({20'h0, s_r.nomon}, s_r.wd, s_r.ws);
               s_nxt.nomon = wv[11:0];
            end
            pcyc_pkg::A_CMDG:
            begin
               wv = wmerge({20'h0, s_r.cmdg}, s_r.wd, s_r.ws);
               s_nxt.cmdg = wv[11:0];
            end
            pcyc_pkg::A_MASK:  s_nxt.msk = s_r.ws[0] ? s_r.wd[3:0] : s_r.msk;
            pcyc_pkg::A_DEP:
            begin
               wv = wmerge({13'h0, s_r.dsel, 4'h0, s_r.dep}, s_r.wd, s_r.ws);
               s_nxt.dep = wv[11:0];
               s_nxt.dsel = wv[pcyc_pkg::DP_SEL +: 3];
            end
            default:
            begin
               if (fol_hit(s_r.awa))
               begin
                  wv = wmerge({20'h0, s_r.fol[s_r.awa[5:2]]}, s_r.wd, s_r.ws);
                  s_nxt.fol[s_r.awa[5:2]] = wv[11:0];
               end
               else
                  s_nxt.bus.bresp = pcyc_pkg::R_SLVERR;
            end
         endcase
      end
      s_nxt.bus.awready = !s_nxt.awok && !s_nxt.bus.bvalid;
      s_nxt.bus.wready = !s_nxt.wok && !s_nxt.bus.bvalid;

      // read side: one read in flight, answer in the next cycle
      if (s_r.bus.rvalid && axi_req.rready)
         s_nxt.bus.rvalid = 1'b0;
      if (axi_req.arvalid && s_r.bus.arready)
      begin
         s_nxt.bus.rvalid = 1'b1;
         s_nxt.bus.rresp = pcyc_pkg::R_OKAY;
         case (axi_req.araddr)
            pcyc_pkg::A_CTRL:  rd = {20'h0, s_r.ctrl};
            pcyc_pkg::A_DLY:   rd = {24'h0, s_r.dly};
            pcyc_pkg::A_TOFF:  rd = {24'h0, s_r.toff};
            pcyc_pkg::A_TON:   rd = {24'h0, s_r.ton};
            pcyc_pkg::A_CONT:  rd = {24'h0, s_r.cont};
            pcyc_pkg::A_RSQ:   rd = {20'h0, s_r.rsq};
            pcyc_pkg::A_IMM:   rd = {20'h0, s_r.imm};
            pcyc_pkg::A_NOMON: rd = {20'h0, s_r.nomon};
            pcyc_pkg::A_DEP:   rd = {13'h0, s_r.dsel, 4'h0, s_r.dep};
            pcyc_pkg::A_CMDG:  rd = {20'h0, s_r.cmdg};
            pcyc_pkg::A_STAT:  rd = {4'h0, s_r.grp, 3'h0, s_r.rtym, s_r.rty,
                                     s_r.warned, s_r.att, 1'b0, s_r.fsm};
            pcyc_pkg::A_IRQ:
            begin
               rd = {28'h0, s_r.ist};
               clr = 4'hF; // read clears, a same-cycle event survives
            end
            pcyc_pkg::A_MASK:  rd = {28'h0, s_r.msk};
            default:
            begin
               if (fol_hit(axi_req.araddr))
                  rd = {20'h0, s_r.fol[axi_req.araddr[5:2]]};
               else
                  s_nxt.bus.rresp = pcyc_pkg::R_SLVERR;
            end
         endcase
         s_nxt.bus.rdata = rd;
      end
      s_nxt.bus.arready = !s_nxt.bus.rvalid;

      // power-cycle sequencing
      case (s_r.fsm)
         pcyc_pkg::S_IDLE:
         begin
            s_nxt.en = s_r.ctrl[pcyc_pkg::CT_ON] ? ~s_r.dead : '0;
            if (!s_r.ctrl[pcyc_pkg::CT_ON])
               s_nxt.dead = '0;
            s_nxt.ms = '0;
            s_nxt.warned = 1'b0;
            if (s_r.ctrl[pcyc_pkg::CT_ON] && |hit)
            begin
               c = lo1(hit);
               s_nxt.now = |(c & s_r.imm);
               s_nxt.fsm = pcyc_pkg::S_CONT;
               if (s_r.rty < rty_lim)
               begin
                  s_nxt.rtym = 1'b1; // faulted rail alone first
                  s_nxt.grp = c;
                  s_nxt.rty = s_r.rty + 4'h1;
               end
               else
               begin
                  s_nxt.rtym = 1'b0;
                  s_nxt.grp = c | folof(c, s_r.fol);
               end
            end
            else if (s_r.ctrl[pcyc_pkg::CT_GO] && s_r.ctrl[pcyc_pkg::CT_ON])
            begin
               s_nxt.grp = s_r.cmdg; // host-ordered cycle
               s_nxt.rtym = 1'b0;
               s_nxt.now = 1'b1;
               s_nxt.fsm = pcyc_pkg::S_CONT;
            end
         end
         pcyc_pkg::S_CONT:
         begin
            // keep running for the continue time unless immediate
            if (s_r.now || s_r.ms >= 11'(s_r.cont))
            begin
               s_nxt.fsm = pcyc_pkg::S_OFF;
               s_nxt.ms = '0;
            end
         end
         pcyc_pkg::S_OFF:
         begin
            // one rail per ms, highest first: soft shutdown
            if (ms_p && |(s_r.en & s_r.grp))
               s_nxt.en = s_r.en & ~hi1(s_r.en & s_r.grp);
            // off means enable low and below the 12.5% comparator
            if (!(|(s_r.en & s_r.grp)) && ((s_r.of2 & s_r.grp) == s_r.grp))
            begin
               s_nxt.fsm = pcyc_pkg::S_DLY;
               s_nxt.ms = '0;
            end
            else if (!s_r.warned && s_r.ms >= 11'(s_r.toff))
            begin
               s_nxt.warned = 1'b1;
               ev[pcyc_pkg::IQ_WARN] = 1'b1;
               if (!s_r.ctrl[pcyc_pkg::CT_CONT])
               begin
                  s_nxt.fsm = pcyc_pkg::S_IDLE; // abandon
                  s_nxt.dead = s_r.dead | s_r.grp;
                  s_nxt.grp = '0;
                  ev[pcyc_pkg::IQ_ABRT] = 1'b1;
               end
            end
         end
         pcyc_pkg::S_DLY:
         begin
            if (s_r.ms >= dly_ms)
            begin
               s_nxt.fsm = pcyc_pkg::S_ON;
               s_nxt.ms = '0;
            end
         end
         pcyc_pkg::S_ON:
         begin
            // lowest rail first, after earlier rails are good
            c = lo1(s_r.grp & ~s_r.en);
            if (ms_p && |c && !(|(s_r.en & s_r.grp & ~good)) &&
                (!(|(c & s_r.dep)) || s_r.gp2[s_r.dsel])) // pin gate
               s_nxt.en = s_r.en | c;
            if (!(|(s_r.grp & ~s_r.en)) && !(|(s_r.grp & ~good)))
            begin
               s_nxt.fsm = pcyc_pkg::S_STB;
               s_nxt.ms = '0;
            end
            else if (s_r.ms >= 11'(s_r.ton))
               fail = 1'b1;
         end
         pcyc_pkg::S_STB:
         begin
            if (|(s_r.grp & ~good))
               fail = 1'b1;
            else if (s_r.ms >= pcyc_pkg::STABLE_MS)
            begin
               s_nxt.att = '0; // one steady second clears it
               s_nxt.rty = '0;
               s_nxt.grp = '0;
               s_nxt.fsm = pcyc_pkg::S_IDLE;
               ev[pcyc_pkg::IQ_DONE] = 1'b1;
            end
         end
         default: s_nxt.fsm = pcyc_pkg::S_IDLE;
      endcase

      // failed to regulate: retry, widen, repeat or give up
      if (fail)
      begin
         s_nxt.fsm = pcyc_pkg::S_OFF;
         s_nxt.ms = '0;
         s_nxt.warned = 1'b0;
         if (s_r.rtym && s_r.rty < rty_lim)
            s_nxt.rty = s_r.rty + 4'h1;
         else if (s_r.rtym)
         begin
            s_nxt.rtym = 1'b0; // retries spent, cycle the group
            s_nxt.grp = s_r.grp | folof(s_r.grp, s_r.fol);
         end
         else if (s_r.att + 3'h1 >= att_lim)
         begin
            s_nxt.fsm = pcyc_pkg::S_IDLE;
            s_nxt.dead = s_r.dead | s_r.grp;
            s_nxt.grp = '0;
            s_nxt.att = '0;
            ev[pcyc_pkg::IQ_GIVE] = 1'b1;
         end
         else
            s_nxt.att = s_r.att + 3'h1;
      end

      // another group joins: union, shared counter and wait
      if (s_r.fsm != pcyc_pkg::S_IDLE && s_nxt.fsm != pcyc_pkg::S_IDLE && |newf)
      begin
         s_nxt.grp = s_nxt.grp | newf | folof(s_nxt.grp | newf, s_r.fol);
         s_nxt.rtym = 1'b0; // remaining attempts only
         if (s_r.fsm == pcyc_pkg::S_DLY || s_r.fsm == pcyc_pkg::S_ON ||
             s_r.fsm == pcyc_pkg::S_STB)
         begin
            s_nxt.fsm = pcyc_pkg::S_OFF; // all off before any on
            s_nxt.ms = '0;
            s_nxt.warned = 1'b0;
         end
      end

      s_nxt.ist = (s_r.ist & ~clr) | ev;
      s_nxt.irq = |(s_nxt.ist & s_nxt.msk);
   end

   // state register
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         s_r <= '0;
         s_r.toff <= pcyc_pkg::TOFF_RST;
         s_r.ton <= pcyc_pkg::TON_RST;
      end
      else
         s_r <= s_nxt;
   end

   assign axi_rsp = s_r.bus;
   assign rail_en = s_r.en;
   assign irq     = s_r.irq;

   // checks
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   AST_GRP_HOLD: assert property ((s_r.fsm == pcyc_pkg::S_DLY) && !(|newf)
      |=> $stable(s_r.grp)) else $error("group changed without new fault");
   AST_SOFT_OFF: assert property ((s_r.fsm == pcyc_pkg::S_OFF)
      |=> $countones($past(s_r.en) & ~s_r.en) <= 1)
      else $error("more than one rail dropped at once");
   AST_DELAY: assert property ((s_r.fsm == pcyc_pkg::S_DLY) && s_r.ms < dly_ms
      && !(|newf) |=> s_r.fsm == pcyc_pkg::S_DLY)
      else $error("delay ended early");
   AST_ATT_LIM: assert property (s_r.att < att_lim)
      else $error("attempt count past limit");
   AST_WARN: assert property ((s_r.fsm == pcyc_pkg::S_OFF) && !s_r.warned
      && s_nxt.fsm == pcyc_pkg::S_OFF && s_r.ms >= 11'(s_r.toff)
      |=> s_r.ist[pcyc_pkg::IQ_WARN]) else $error("warning lost");
   AST_ABANDON: assert property ((s_r.fsm == pcyc_pkg::S_OFF) && s_nxt.warned
      && !s_r.warned && !s_r.ctrl[pcyc_pkg::CT_CONT] |=> s_r.fsm == pcyc_pkg::S_IDLE)
      else $error("abandon not taken");
   AST_STABLE: assert property ((s_r.fsm == pcyc_pkg::S_STB) && s_r.att != 3'h0
      && s_r.ms < pcyc_pkg::STABLE_MS |=> s_r.att != 3'h0)
      else $error("attempts cleared too soon");
   AST_MERGE: assert property ((s_r.fsm == pcyc_pkg::S_ON) && |newf
      && s_nxt.fsm != pcyc_pkg::S_IDLE |=> s_r.fsm == pcyc_pkg::S_OFF)
      else $error("join did not restart shutdown");
   AST_RTY: assert property (s_r.rty <= pcyc_pkg::RTY_MAX)
      else $error("retry count too high");
   AST_IRQ: assert property (s_r.irq == |(s_r.ist & s_r.msk))
      else $error("interrupt out of step");

   COV_DONE: cover property (s_r.ist[pcyc_pkg::IQ_DONE] && !$past(s_r.ist[1]));
   COV_GIVE: cover property (s_r.ist[pcyc_pkg::IQ_GIVE]);
   COV_JOIN: cover property ((s_r.fsm == pcyc_pkg::S_OFF) && |newf);
endmodule

// [rtl/pcyc_pkg.sv]
// constants, register map and types of the fault power-cycle sequencer
package pcyc_pkg;
   localparam int NR = 12;
   localparam int NG = 8;
   // register byte offsets
   localparam logic [7:0] A_CTRL  = 8'h00;
   localparam logic [7:0] A_DLY   = 8'h04;
   localparam logic [7:0] A_TOFF  = 8'h08;
   localparam logic [7:0] A_TON   = 8'h0C;
   localparam logic [7:0] A_CONT  = 8'h10;
   localparam logic [7:0] A_RSQ   = 8'h14;
   localparam logic [7:0] A_IMM   = 8'h18;
   localparam logic [7:0] A_NOMON = 8'h1C;
   localparam logic [7:0] A_DEP   = 8'h20;
   localparam logic [7:0] A_CMDG  = 8'h24;
   localparam logic [7:0] A_STAT  = 8'h28;
   localparam logic [7:0] A_IRQ   = 8'h2C;
   localparam logic [7:0] A_MASK  = 8'h30;
   localparam logic [1:0] A_FOLHI = 2'h1;
   // field positions
   localparam int CT_ON   = 0;
   localparam int CT_CONT = 1;
   localparam int CT_GO   = 2;
   localparam int CT_ATT  = 4;
   localparam int CT_RTY  = 8;
   localparam int DP_SEL  = 16;
   localparam int IQ_WARN = 0;
   localparam int IQ_DONE = 1;
   localparam int IQ_GIVE = 2;
   localparam int IQ_ABRT = 3;
   // reset values and retry ceiling
   localparam logic [7:0] TOFF_RST = 8'h0A;
   localparam logic [7:0] TON_RST  = 8'h32;
   localparam logic [3:0] RTY_MAX  = 4'hE;
   // timing and bus response codes
   localparam int CLK_HZ = 10_000_000;
   localparam int MS_CYC = CLK_HZ / 1000;
   localparam logic [10:0] STEP_MS   = 11'h005;
   localparam logic [10:0] STABLE_S  = 11'h001;
   localparam logic [10:0] STABLE_MS = 11'(STABLE_S * 11'h3E8);
   localparam logic [1:0] R_OKAY   = 2'h0;
   localparam logic [1:0] R_SLVERR = 2'h2;

   typedef enum logic [2:0] {
      S_IDLE = 3'h0, S_CONT = 3'h1, S_OFF = 3'h3,
      S_DLY = 3'h2, S_ON = 3'h6, S_STB = 3'h7
   } fsm_t;

   typedef struct packed {
      logic        awvalid;
      logic [7:0]  awaddr;
      logic        wvalid;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic        bready;
      logic        arvalid;
      logic [7:0]  araddr;
      logic        rready;
   } axi_req_t;

   typedef struct packed {
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [1:0]  rresp;
      logic [31:0] rdata;
   } axi_rsp_t;

   typedef struct packed {
      fsm_t                fsm;
      logic [NR-1:0]       en, grp, dead, pg1, pg2, of1, of2;
      logic [NG-1:0]       gp1, gp2;
      logic [11:0]         ctrl;
      logic [7:0]          dly, toff, ton, cont;
      logic [NR-1:0]       rsq, imm, nomon, dep, cmdg;
      logic [2:0]          dsel;
      logic [NR-1:0][NR-1:0] fol;
      logic [3:0]          ist, msk;
      logic [13:0]         tick;
      logic [10:0]         ms;
      logic [2:0]          att;
      logic [3:0]          rty;
      logic                rtym, now, warned;
      logic                awok, wok;
      logic [7:0]          awa;
      logic [31:0]         wd;
      logic [3:0]          ws;
      axi_rsp_t            bus;
      logic                irq;
   } st_t;
endpackage

// [sim/rail_model.sv]
// behavioural supply rails that answer the sequencer's enables
`timescale 1ns/1ps
module rail_model #(
   parameter int LAT = 3
) (
   input  wire logic        clk,
   input  wire logic [11:0] en,
   input  wire logic [11:0] stuck_low,
   input  wire logic [11:0] no_good,
   output logic      [11:0] pgood,
   output logic      [11:0] low
);
   logic [11:0] hist [LAT];

   // enable history stands in for the ramp time of each supply
   always_ff @(posedge clk)
   begin
      hist[0] <= en;
      for (int i = 1; i < LAT; i++)
         hist[i] <= hist[i-1];
   end

   // a stuck rail never discharges, a weak rail never reaches good
   assign pgood = hist[LAT-1] & en & ~no_good;
   assign low   = ~hist[LAT-1] & ~en & ~stuck_low; // under 12.5 percent
endmodule

// [sim/fault_power_cycle_sequencer_tb_top.sv]
// self-checking bench of the fault power-cycle sequencer
`timescale 1ns/1ps
module fault_power_cycle_sequencer_tb_top;
   logic                mclk;
   logic                rst;
   pcyc_pkg::axi_req_t  req;
   pcyc_pkg::axi_rsp_t  rsp;
   logic [11:0]         rail_fault;
   logic [11:0]         pgood;
   logic [11:0]         low;
   logic [7:0]          gpi;
   logic [11:0]         rail_en;
   logic                irq;
   logic [11:0]         stuck_low;
   logic [11:0]         no_good;
   int                  n_errors;
   int                  n_checks;
   int                  off_cyc;

   // ten cycles per ms keeps the one second stable wait short
   fault_power_cycle_sequencer #(.MS_CYC(10)) DUT (
      .mclk       (mclk),
      .rst        (rst),
      .axi_req    (req),
      .axi_rsp    (rsp),
      .rail_fault (rail_fault),
      .rail_pgood (pgood),
      .rail_low   (low),
      .gpi        (gpi),
      .rail_en    (rail_en),
      .irq        (irq)
   );

   rail_model #(.LAT(3)) rails (
      .clk       (mclk),
      .en        (rail_en),
      .stuck_low (stuck_low),
      .no_good   (no_good),
      .pgood     (pgood),
      .low       (low)
   );

   // 10 MHz clock
   always #50 mclk = ~mclk;

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
   begin
      n_checks++;
      if (got !== exp)
      begin
         n_errors++;
         $display("[FAIL] %0t %s", $time, msg);
      end
   end
   endtask

   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
      int n;
   begin
      n = 0;
      @(posedge mclk);
      req.awvalid <= 1'b1;
      req.awaddr  <= a;
      req.wvalid  <= 1'b1;
      req.wdata   <= d;
      req.wstrb   <= 4'hF;
      req.bready  <= 1'b1;
      do
      begin
         @(posedge mclk);
         n++;
         if (req.awvalid && rsp.awready)
            req.awvalid <= 1'b0;
         if (req.wvalid && rsp.wready)
            req.wvalid <= 1'b0;
      end while (!rsp.bvalid && n < 100);
      chk({31'h0, rsp.bvalid}, 32'h1, "write answer");
      req.bready <= 1'b0;
      chk({30'h0, rsp.bresp}, 32'h0, "write response");
   end
   endtask

   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
   begin
      n = 0;
      @(posedge mclk);
      req.arvalid <= 1'b1;
      req.araddr  <= a;
      req.rready  <= 1'b1;
      do
      begin
         @(posedge mclk);
         n++;
         if (req.arvalid && rsp.arready)
            req.arvalid <= 1'b0;
      end while (!rsp.rvalid && n < 100);
      chk({31'h0, rsp.rvalid}, 32'h1, "read answer");
      d = rsp.rdata;
      r = rsp.rresp;
      req.rready <= 1'b0;
   end
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string msg);
      logic [31:0] d;
      logic [1:0]  r;
   begin
      axi_rd(a, d, r);
      chk(d, exp, msg);
   end
   endtask

   // bounded wait for masked enables to reach a value
   task automatic wait_en(input logic [11:0] m, input logic [11:0] v);
      int n;
   begin
      n = 0;
      while ((rail_en & m) !== v && n < 3000)
      begin
         @(posedge mclk);
         n++;
      end
      chk({20'h0, rail_en & m}, {20'h0, v}, "rail enables");
   end
   endtask

   // fault rail 0 whose group is rails 0 and 1, then judge the outcome
   task automatic run_fault(input logic [31:0] ctrl, input logic [11:0] sl,
                            input logic [11:0] ng, input logic [31:0] exp);
      int n;
   begin
      axi_wr(pcyc_pkg::A_CTRL, 32'h0);
      axi_wr(pcyc_pkg::A_CTRL, ctrl);
      wait_en(12'hFFF, 12'hFFF);
      stuck_low  <= sl;
      no_good    <= ng;
      rail_fault <= 12'h001;
      wait_en(12'h002, 12'h000);
      chk({31'h0, rail_en[0]}, 32'h1, "soft order");
      wait_en(12'h001, 12'h000);
      chk({20'h0, rail_en}, 32'hFFC, "group only");
      rail_fault <= 12'h000;
      off_cyc = 0;
      n = 0;
      while (irq !== 1'b1 && n < 30000)
      begin
         @(posedge mclk);
         n++;
         if (rail_en[0] === 1'b0 && n == off_cyc + 1)
            off_cyc = n;
      end
      rd_chk(pcyc_pkg::A_IRQ, exp, "event status");
      rd_chk(pcyc_pkg::A_IRQ, 32'h0, "status read clear");
      chk({31'h0, irq}, 32'h0, "interrupt level");
      stuck_low <= 12'h000;
      no_good   <= 12'h000;
   end
   endtask

   // a second faulted group joins while the first powers up again
   task automatic test_join;
      int n;
   begin
      axi_wr(pcyc_pkg::A_CTRL, 32'h0);
      axi_wr(pcyc_pkg::A_RSQ, 32'h005);
      axi_wr(pcyc_pkg::A_CTRL, 32'h1);
      wait_en(12'hFFF, 12'hFFF);
      rail_fault <= 12'h001;
      wait_en(12'h001, 12'h000);
      rail_fault <= 12'h000;
      wait_en(12'h001, 12'h001);
      rail_fault <= 12'h004;
      wait_en(12'h004, 12'h000);
      rail_fault <= 12'h000;
      n = 0;
      while (irq !== 1'b1 && n < 30000)
      begin
         @(posedge mclk);
         n++;
      end
      rd_chk(pcyc_pkg::A_IRQ, 32'h2, "join status");
      chk({20'h0, rail_en}, 32'hFFF, "join restored");
      axi_wr(pcyc_pkg::A_RSQ, 32'h001);
   end
   endtask

   task automatic test_regs;
      logic [31:0] d;
      logic [1:0]  r;
   begin
      rd_chk(pcyc_pkg::A_TOFF, 32'h0000000A, "toff reset");
      rd_chk(pcyc_pkg::A_TON, 32'h00000032, "ton reset");
      axi_rd(8'hFC, d, r);
      chk({30'h0, r}, {30'h0, pcyc_pkg::R_SLVERR}, "unmapped read");
      axi_wr(pcyc_pkg::A_DLY, 32'h2);
      axi_wr(pcyc_pkg::A_RSQ, 32'h001);
      axi_wr(8'h40, 32'h003);
      axi_wr(pcyc_pkg::A_MASK, 32'hF);
   end
   endtask

   task automatic give_verdict;
   begin
      if (n_errors == 0 && n_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   end
   endtask

   // watchdog well beyond the three fault runs
   initial
   begin
      repeat (80000) @(posedge mclk);
      n_errors++;
      give_verdict();
   end

   initial
   begin
      mclk       = 1'b0;
      rst        = 1'b1;
      req        = '0;
      rail_fault = 12'h000;
      gpi        = 8'h00;
      stuck_low  = 12'h000;
      no_good    = 12'h000;
      n_errors   = 0;
      n_checks   = 0;
      repeat (20) @(posedge mclk);
      rst <= 1'b0;
      repeat (2) @(posedge mclk);
      test_regs();
      run_fault(32'h1, 12'h000, 12'h000, 32'h2);
      chk(32'(off_cyc >= 100 && off_cyc <= 150), 32'h1, "off delay");
      chk({20'h0, rail_en}, 32'hFFF, "restored");
      test_join();
      run_fault(32'h1, 12'h002, 12'h000, 32'h9);
      run_fault(32'h11, 12'h000, 12'h002, 32'h4);
      give_verdict();
   end
endmodule
